/* hw/irq_router_host.sv */
// Processor end: turns commands into whole-word bus transfers
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module irq_router_host
    import irq_router_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Command port
    input  wire logic        cmd_valid_i,
    input  wire cmd_type     cmd_i,
    input  wire logic [31:0] cmd_data_i,
    output logic             cmd_ready_o,
    // Result port
    output logic             done_o,
    output logic [31:0]      rdata_o,
    output logic             error_o,
    // Processor bus
    irq_router_if.host       bus
);
    typedef struct packed
    {
        host_state_type state;
        logic           psel;
        logic           penable;
        logic           pwrite;
        logic [7:0]     paddr;
        logic [31:0]    pwdata;
        logic           done;
        logic [31:0]    rdata;
        logic           error;
        logic           idle;
    } host_type;

    host_type h_q;
    host_type h_d;

    // ==========================================================
    // Every access is a full 32-bit word transfer
    always_comb
    begin
        h_d      = h_q;
        h_d.done = 1'b0;
        case (h_q.state)
            ST_IDLE:
            begin
                if (cmd_valid_i)
                begin
                    h_d.state  = ST_SETUP;
                    h_d.psel   = 1'b1;
                    h_d.pwrite = (cmd_i == CMD_WRITE_SELECT) || (cmd_i == CMD_WRITE_WINDOW);
                    h_d.paddr  = (cmd_i == CMD_WRITE_SELECT || cmd_i == CMD_READ_SELECT)
                                 ? SELECT_OFFSET : WINDOW_OFFSET;
                    h_d.pwdata = cmd_data_i;
                end
            end
            ST_SETUP:
            begin
                h_d.state   = ST_ACCESS;
                h_d.penable = 1'b1;
            end
            ST_ACCESS:
            begin
                // Wait as long as the device needs; no cycle count assumed
                if (bus.pready)
                begin
                    h_d.state   = ST_IDLE;
                    h_d.psel    = 1'b0;
                    h_d.penable = 1'b0;
                    h_d.done    = 1'b1;
                    h_d.error   = bus.pslverr;
                    if (!h_q.pwrite)
                        h_d.rdata = bus.prdata;
                end
            end
            default:
                h_d.state = ST_IDLE;
        endcase
        // Ready is registered so the command side sees a flop, not decode
        h_d.idle = (h_d.state == ST_IDLE);
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            h_q.state   <= ST_IDLE;
            h_q.psel    <= 1'b0;
            h_q.penable <= 1'b0;
            h_q.pwrite  <= 1'b0;
            h_q.paddr   <= 8'h00;
            h_q.pwdata  <= 32'h0000_0000;
            h_q.done    <= 1'b0;
            h_q.rdata   <= 32'h0000_0000;
            h_q.error   <= 1'b0;
            h_q.idle    <= 1'b1;
        end
        else
        begin
            h_q <= h_d;
        end
    end

    assign cmd_ready_o = h_q.idle;
    assign done_o      = h_q.done;
    assign rdata_o     = h_q.rdata;
    assign error_o     = h_q.error;
    assign bus.psel    = h_q.psel;
    assign bus.penable = h_q.penable;
    assign bus.pwrite  = h_q.pwrite;
    assign bus.paddr   = h_q.paddr;
    assign bus.pwdata  = h_q.pwdata;
endmodule // irq_router_host
`default_nettype wire

/* hw/irq_router_pkg.sv */
// Constants and types shared by the interrupt router register front end
`default_nettype none
package irq_router_pkg;
    // ==========================================================
    // Memory-mapped offsets (byte addresses)
    localparam logic [7:0]  SELECT_OFFSET   = 8'h00;
    localparam logic [7:0]  WINDOW_OFFSET   = 8'h10;
    // Indirect register indices
    localparam logic [7:0]  IDX_UNIT_ID     = 8'h00;
    localparam logic [7:0]  IDX_VERSION     = 8'h01;
    localparam logic [7:0]  IDX_ARB_PRIO    = 8'h02;
    // Field positions
    localparam int          SEL_IDX_LSB     = 0;
    localparam int          ID_FIELD_LSB    = 24;
    localparam int          MAX_ENTRY_LSB   = 16;
    localparam int          VERSION_LSB     = 0;
    // Reset and fixed values
    localparam logic [7:0]  SELECT_RESET    = 8'h00;
    localparam logic [3:0]  UNIT_ID_RESET   = 4'h0;
    localparam logic [3:0]  ARB_PRIO_RESET  = 4'h0;
    localparam logic [7:0]  MAX_ENTRY_VALUE = 8'h0f;
    localparam logic [7:0]  VERSION_CODE    = 8'h5a; // Value is arbitrary
    // Host command codes
    typedef enum logic [1:0]
    {
        CMD_WRITE_SELECT = 2'h0,
        CMD_WRITE_WINDOW = 2'h1,
        CMD_READ_WINDOW  = 2'h2,
        CMD_READ_SELECT  = 2'h3
    } cmd_type;
    // Host state machine, one-hot
    typedef enum logic [2:0]
    {
        ST_IDLE   = 3'b001,
        ST_SETUP  = 3'b010,
        ST_ACCESS = 3'b100
    } host_state_type;
endpackage : irq_router_pkg
`default_nettype wire

/* hw/irq_router_if.sv */
// Memory-bus carrier between processor end and register front end
`timescale 1ns/1ps
`default_nettype none
interface irq_router_if;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;

    modport device (input psel, penable, pwrite, paddr, pwdata,
                    output prdata, pready, pslverr);
    modport host   (output psel, penable, pwrite, paddr, pwdata,
                    input prdata, pready, pslverr);
endinterface : irq_router_if
`default_nettype wire

/* hw/irq_router_regs.sv */
// Indirect register file behind the data window
`timescale 1ns/1ps
`default_nettype none
module irq_router_regs
    import irq_router_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Window access
    input  wire logic [7:0]  index_i,
    input  wire logic        wr_i,
    input  wire logic [31:0] wdata_i,
    output logic      [31:0] rdata_o,
    // Device state
    output logic      [3:0]  unit_id_o,
    output logic      [3:0]  arb_prio_o
);
    typedef struct packed
    {
        logic [3:0] unit_id;
        logic [3:0] arb_prio;
    } regs_type;

    regs_type state_q;
    regs_type state_d;

    // ==========================================================
    // Writes: only the identification index is writable
    always_comb
    begin
        state_d = state_q;
        if (wr_i && index_i == IDX_UNIT_ID)
        begin
            state_d.unit_id  = wdata_i[ID_FIELD_LSB +: 4];
            state_d.arb_prio = wdata_i[ID_FIELD_LSB +: 4];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_q.unit_id  <= UNIT_ID_RESET;
            state_q.arb_prio <= ARB_PRIO_RESET;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // ==========================================================
    // Read mux, combinational so window reads see current state
    always_comb
    begin
        rdata_o = 32'h0000_0000;
        case (index_i)
            IDX_UNIT_ID:
                rdata_o[ID_FIELD_LSB +: 4] = state_q.unit_id;
            IDX_VERSION:
            begin
                rdata_o[MAX_ENTRY_LSB +: 8] = MAX_ENTRY_VALUE;
                rdata_o[VERSION_LSB +: 8]   = VERSION_CODE;
            end
            IDX_ARB_PRIO:
                rdata_o[ID_FIELD_LSB +: 4] = state_q.arb_prio;
            default:
                rdata_o = 32'h0000_0000;
        endcase
    end

    assign unit_id_o  = state_q.unit_id;
    assign arb_prio_o = state_q.arb_prio;
endmodule // irq_router_regs
`default_nettype wire

/* hw/irq_router_device.sv */
// Register front end: select register, data window and bus answer
`timescale 1ns/1ps
`default_nettype none
module irq_router_device
    import irq_router_pkg::*;
(
    // Clock and reset
    input  wire logic     clk_i,
    input  wire logic     rst_i,
    // Processor bus
    irq_router_if.device  bus,
    // Device state
    output logic [3:0]    unit_id_o,
    output logic [3:0]    arb_prio_o
);
    typedef struct packed
    {
        logic [7:0]  select;
        logic        ready;
        logic        slverr;
        logic [31:0] rdata;
    } dev_type;

    dev_type     state_q;
    dev_type     state_d;
    logic        setup;
    logic        win_wr;
    logic [31:0] win_rdata;
    logic [3:0]  uid;
    logic [3:0]  arb;

    // Accept on the setup cycle; answer in the access phase one cycle later
    assign setup  = bus.psel && !bus.penable;
    assign win_wr = setup && bus.pwrite && bus.paddr == WINDOW_OFFSET;

    irq_router_regs u_regs
    (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .index_i    (state_q.select),
        .wr_i       (win_wr),
        .wdata_i    (bus.pwdata),
        .rdata_o    (win_rdata),
        .unit_id_o  (uid),
        .arb_prio_o (arb)
    );

    // ==========================================================
    // Decode; unmapped offsets give an error answer, no effect
    always_comb
    begin
        state_d        = state_q;
        state_d.ready  = 1'b0;
        state_d.slverr = 1'b0;
        if (setup)
        begin
            state_d.ready = 1'b1;
            state_d.rdata = 32'h0000_0000;
            case (bus.paddr)
                SELECT_OFFSET:
                begin
                    if (bus.pwrite)
                        state_d.select = bus.pwdata[SEL_IDX_LSB +: 8];
                    else
                        state_d.rdata[SEL_IDX_LSB +: 8] = state_q.select;
                end
                WINDOW_OFFSET:
                begin
                    if (!bus.pwrite)
                        state_d.rdata = win_rdata;
                end
                default:
                    state_d.slverr = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_q.select <= SELECT_RESET;
            state_q.ready  <= 1'b0;
            state_q.slverr <= 1'b0;
            state_q.rdata  <= 32'h0000_0000;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign bus.pready  = state_q.ready;
    assign bus.pslverr = state_q.slverr;
    assign bus.prdata  = state_q.rdata;
    assign unit_id_o   = uid;   // Register inside u_regs
    assign arb_prio_o  = arb;
endmodule // irq_router_device
`default_nettype wire

/* verif/irq_router_monitor.sv */
// Bus and register checker for the interrupt router front end
`timescale 1ns/1ps
`default_nettype none
module irq_router_monitor
    import irq_router_pkg::*;
(
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // Bus signals
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    // ==========================================================
    // Shadow state, updated at the setup edge like the device
    logic [7:0] sel_q;
    logic [3:0] id_q;
    logic       setup;
    logic       win_rd;
    assign setup  = psel && !penable;
    assign win_rd = setup && !pwrite && paddr == WINDOW_OFFSET;
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sel_q <= 8'h00;
            id_q  <= 4'h0;
        end
        else if (setup && pwrite && paddr == SELECT_OFFSET)
            sel_q <= pwdata[7:0];
        else if (setup && pwrite && paddr == WINDOW_OFFSET && sel_q == IDX_UNIT_ID)
            id_q <= pwdata[27:24];
    end
    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ready_after_setup_a: assert property (setup |=> psel && penable && pready)
        else $error("no answer after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    bad_offset_err_a: assert property (setup && paddr != SELECT_OFFSET &&
        paddr != WINDOW_OFFSET |=> pslverr && prdata == 32'h0) else $error("no refusal");
    good_offset_ok_a: assert property (setup && (paddr == SELECT_OFFSET ||
        paddr == WINDOW_OFFSET) |=> !pslverr) else $error("spurious refusal");
    select_readback_a: assert property (setup && !pwrite && paddr == SELECT_OFFSET
        |=> prdata == {24'h0, sel_q}) else $error("select read back wrong");
    version_word_a: assert property (win_rd && sel_q == IDX_VERSION
        |=> prdata == {8'h00, 8'h0f, 8'h00, VERSION_CODE}) else $error("version wrong");
    id_word_a: assert property (win_rd && (sel_q == IDX_UNIT_ID ||
        sel_q == IDX_ARB_PRIO) |=> prdata == {4'h0, id_q, 24'h0}) else $error("id wrong");
    free_index_a: assert property (win_rd && sel_q > IDX_ARB_PRIO |=> prdata == 32'h0)
        else $error("free index not zero");
    // Main scenarios
    cover property (setup && pwrite && paddr == WINDOW_OFFSET && sel_q == IDX_UNIT_ID);
    cover property (win_rd && sel_q == IDX_VERSION);
    cover property (win_rd && sel_q > IDX_ARB_PRIO);
endmodule // irq_router_monitor
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench joining processor end and register front end
`timescale 1ns/1ps
`default_nettype none
module tb
    import irq_router_pkg::*;
;
    // ==========================================================
    // Stimulus and observed signals
    logic        clk_i       = 1'b0;
    logic        rst_i       = 1'b1;
    logic        cmd_valid_i = 1'b0;
    cmd_type     cmd_i       = CMD_READ_SELECT;
    logic [31:0] cmd_data_i  = 32'h0;
    logic        cmd_ready_o;
    logic        done_o;
    logic [31:0] rdata_o;
    logic        error_o;
    logic [3:0]  unit_id_o;
    logic [3:0]  arb_prio_o;
    int          errors      = 0;
    int          tests_run   = 0;
    int          cycles      = 0;
    irq_router_if u_irq_router_if ();
    irq_router_host u_irq_router_host (.clk_i(clk_i), .rst_i(rst_i),
        .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_data_i(cmd_data_i),
        .cmd_ready_o(cmd_ready_o), .done_o(done_o), .rdata_o(rdata_o),
        .error_o(error_o), .bus(u_irq_router_if));
    irq_router_device u_irq_router_device (.clk_i(clk_i), .rst_i(rst_i),
        .bus(u_irq_router_if), .unit_id_o(unit_id_o), .arb_prio_o(arb_prio_o));
    irq_router_monitor u_irq_router_monitor (.clk_i(clk_i), .rst_i(rst_i),
        .psel(u_irq_router_if.psel), .penable(u_irq_router_if.penable),
        .pwrite(u_irq_router_if.pwrite), .paddr(u_irq_router_if.paddr),
        .pwdata(u_irq_router_if.pwdata), .prdata(u_irq_router_if.prdata),
        .pready(u_irq_router_if.pready), .pslverr(u_irq_router_if.pslverr));
    always #25 clk_i = ~clk_i;
    // ==========================================================
    // Shared tasks
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Waits are bounded so a stuck handshake shows up as a mismatch
    task automatic cmd(input cmd_type c, input logic [31:0] d);
        int n;
        n = 0;
        while (cmd_ready_o !== 1'b1 && n < 20)
        begin
            @(negedge clk_i);
            n++;
        end
        @(posedge clk_i);
        cmd_valid_i <= 1'b1;
        cmd_i       <= c;
        cmd_data_i  <= d;
        @(posedge clk_i);
        cmd_valid_i <= 1'b0;
        n = 0;
        do
        begin
            @(negedge clk_i);
            n++;
        end
        while (done_o !== 1'b1 && n < 20);
        chk("done", 32'h1, {31'h0, done_o});
    endtask
    task automatic rd(input cmd_type c, input logic [31:0] exp);
        cmd(c, 32'h0);
        chk("rdata", exp, rdata_o);
        chk("error", 32'h0, {31'h0, error_o});
    endtask
    // ==========================================================
    // Scenarios
    task reset_values;
        rd(CMD_READ_SELECT, 32'h0);
        rd(CMD_READ_WINDOW, 32'h0);
        chk("arb", 32'h0, {28'h0, arb_prio_o});
    endtask
    task id_loads_arb;
        cmd(CMD_WRITE_WINDOW, 32'hfa5a5a5a);
        chk("unit_id", 32'ha, {28'h0, unit_id_o});
        chk("arb", 32'ha, {28'h0, arb_prio_o});
        rd(CMD_READ_WINDOW, 32'h0a000000);
        cmd(CMD_WRITE_SELECT, 32'hffffff02);
        rd(CMD_READ_SELECT, 32'h2);
        rd(CMD_READ_WINDOW, 32'h0a000000);
    endtask
    task read_only_writes;
        cmd(CMD_WRITE_WINDOW, 32'h05000000);
        rd(CMD_READ_WINDOW, 32'h0a000000);
        cmd(CMD_WRITE_SELECT, 32'h1);
        cmd(CMD_WRITE_WINDOW, 32'hffffffff);
        rd(CMD_READ_WINDOW, {8'h00, 8'h0f, 8'h00, VERSION_CODE});
        chk("arb", 32'ha, {28'h0, arb_prio_o});
    endtask
    task free_indices;
        for (int i = 3; i < 260; i += 84)
        begin
            cmd(CMD_WRITE_SELECT, 32'(i));
            cmd(CMD_WRITE_WINDOW, 32'hffffffff);
            rd(CMD_READ_WINDOW, 32'h0);
        end
        chk("unit_id", 32'ha, {28'h0, unit_id_o});
    endtask
    // Second reset in mid-run must clear select and identification
    task mid_reset;
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        chk("unit_id", 32'h0, {28'h0, unit_id_o});
        chk("arb", 32'h0, {28'h0, arb_prio_o});
        rd(CMD_READ_SELECT, 32'h0);
        rd(CMD_READ_WINDOW, 32'h0);
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ==========================================================
    // Main sequence and hang guard
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errors++;
            tally_and_finish;
        end
    end
    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        reset_values;
        id_loads_arb;
        read_only_writes;
        free_indices;
        mid_reset;
        tally_and_finish;
    end
endmodule // tb
`default_nettype wire
